//--- dv/cml_core_model.sv
// core-side requester model that issues code-table reads
`timescale 1ns/1ps
`default_nettype none
module cml_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // code-table read port
  output cml_pkg::cml_core_req_t core_req,
  input wire cml_pkg::cml_core_rsp_t core_rsp
);
  // ************************************************************
  // request driver
  // ************************************************************
  initial begin
    core_req = '0;
  end

  // one read at a time; result is x when no answer comes
  task automatic fetch(input logic [12:0] a, input logic e, output logic [7:0] d,
                       output logic b);
    int n;
    d = 'x;
    b = 1'bx;
    @(posedge pclk);
    core_req <= '{req: 1'b1, ext: e, addr: a};
    @(posedge pclk);
    // idle lines scrambled so a stale address is never reused
    core_req <= '{req: 1'b0, ext: ~e, addr: ~a};
    for (n = 0; n < 8; n++) begin
      @(posedge pclk);
      if (presetn && core_rsp.valid === 1'b1) begin
        d = core_rsp.data;
        b = core_rsp.blocked;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- dv/test_code_memory_lock_and_encryption.sv
// self-checking bench for the code memory lock block
`timescale 1ns/1ps
`default_nettype none
module test_code_memory_lock_and_encryption;
  // ************************************************************
  // signals
  // ************************************************************
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cml_pkg::cml_core_req_t core_req;
  cml_pkg::cml_core_rsp_t core_rsp;
  logic external_access_select;
  logic ext_access_eff;
  logic ext_exec_allow;
  int fail_count;
  int cmp_count;
  logic [31:0] rd;
  logic err;
  logic [7:0] cd;
  logic cb;

  cml_top #(.ERASABLE(1'b1)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_req, .core_rsp, .external_access_select,
    .ext_access_eff, .ext_exec_allow);
  cml_core_model i_core (.pclk, .presetn, .core_req, .core_rsp);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // one apb transfer; result left in rd and err
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fail_count++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_cmd(input cml_pkg::cml_cmd_t c, input logic [12:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, cml_pkg::OFF_ADDR, {19'h0, a});
    apb(1'b1, cml_pkg::OFF_WDATA, {24'h0, d});
    apb(1'b1, cml_pkg::OFF_CMD, {28'h0, c});
    for (n = 0; n < 16; n++) begin
      apb(1'b0, cml_pkg::OFF_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 16) begin
      fail_count++;
      close_out();
    end
  endtask

  // verify then fetch the result register
  task automatic vfy(input logic [12:0] a);
    run_cmd(cml_pkg::CMD_VERIFY, a, 8'h00);
    apb(1'b0, cml_pkg::OFF_RDATA, 32'h0);
  endtask

  task automatic stat_chk(input logic [2:0] lk, input logic [2:0] lv, input logic ex,
                          input logic rf);
    apb(1'b0, cml_pkg::OFF_STATUS, 32'h0);
    // pin is high at every reset and at every level 1 status read
    chk(rd, {21'h0, lk, 1'b0, lv, ex, 1'b1, rf, 1'b0});
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    fail_count = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    external_access_select = 1'b1;
    do_reset();
    stat_chk(3'h0, cml_pkg::LEVEL_1, 1'b1, 1'b0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    // blank encryption leaves code readable as stored
    run_cmd(cml_pkg::CMD_PROG_CODE, 13'h0041, 8'h5A);
    run_cmd(cml_pkg::CMD_PROG_CODE, 13'h1FFF, 8'h33);
    run_cmd(cml_pkg::CMD_PROG_CODE, 13'h0002, 8'h96); // unused byte given filler
    vfy(13'h0041);
    chk(rd, 32'h5A);
    vfy(13'h1FFF);
    chk(rd, 32'h33);
    run_cmd(cml_pkg::CMD_PROG_ENC, 13'h0001, 8'h0F);
    vfy(13'h0041);
    chk(rd, 32'hAA);
    vfy(13'h1FC1);
    chk(rd, 32'h0F);
    vfy(13'h1FC2);
    chk(rd, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      run_cmd(cml_pkg::CMD_READ_SIG, 13'(i), 8'h00);
      apb(1'b0, cml_pkg::OFF_RDATA, 32'h0);
      chk(rd, {24'h0, cml_pkg::SIG_VALUES[i]});
    end
    i_core.fetch(13'h0041, 1'b1, cd, cb);
    chk({cb, cd}, 32'h05A);
    // level 1: pin followed live
    external_access_select <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(ext_access_eff, 32'h0);
    external_access_select <= 1'b1;
    repeat (3) @(posedge pclk);
    // locked only after the code checks above
    run_cmd(cml_pkg::CMD_PROG_LOCK1, 13'h0000, 8'h00);
    stat_chk(3'h1, cml_pkg::LEVEL_2, 1'b1, 1'b0);
    i_core.fetch(13'h0041, 1'b1, cd, cb);
    chk({cb, cd}, 32'h100);
    i_core.fetch(13'h0041, 1'b0, cd, cb);
    chk({cb, cd}, 32'h05A);
    external_access_select <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(ext_access_eff, 32'h1);
    run_cmd(cml_pkg::CMD_PROG_CODE, 13'h0041, 8'h00);
    run_cmd(cml_pkg::CMD_PROG_ENC, 13'h0001, 8'h00);
    stat_chk(3'h1, cml_pkg::LEVEL_2, 1'b1, 1'b1);
    vfy(13'h0041);
    chk(rd, 32'hAA);
    apb(1'b1, cml_pkg::OFF_STATUS, 32'h2);
    stat_chk(3'h1, cml_pkg::LEVEL_2, 1'b1, 1'b0);
    // level 3 from a fresh reset; arrays survive it
    external_access_select <= 1'b1;
    do_reset();
    vfy(13'h0041);
    chk(rd, 32'hAA);
    run_cmd(cml_pkg::CMD_PROG_LOCK2, 13'h0000, 8'h00);
    stat_chk(3'h2, cml_pkg::LEVEL_3, 1'b1, 1'b0);
    run_cmd(cml_pkg::CMD_READ_SIG, 13'h0000, 8'h00);
    vfy(13'h0041);
    chk(rd, {24'h0, cml_pkg::SIG_VALUES[0]});
    i_core.fetch(13'h0041, 1'b1, cd, cb);
    chk({cb, cd}, 32'h100);
    apb(1'b1, cml_pkg::OFF_STATUS, 32'h2);
    run_cmd(cml_pkg::CMD_PROG_LOCK3, 13'h0000, 8'h00);
    stat_chk(3'h6, cml_pkg::LEVEL_4, 1'b0, 1'b0);
    chk(ext_exec_allow, 32'h0);
    // level 4 alone, then a lower bit added on top
    do_reset();
    run_cmd(cml_pkg::CMD_PROG_LOCK3, 13'h0000, 8'h00);
    run_cmd(cml_pkg::CMD_PROG_LOCK1, 13'h0000, 8'h00);
    stat_chk(3'h5, cml_pkg::LEVEL_4, 1'b0, 1'b0);
    i_core.fetch(13'h1FFF, 1'b1, cd, cb);
    chk({cb, cd}, 32'h100);
    close_out();
  end
endmodule
`default_nettype wire

//--- hdl/cml_mem.sv
// byte-wide array with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module cml_mem #(
  parameter int AW = 13,
  parameter int DEPTH = 8192
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read side
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  // ************************************************************
  // blank state
  // ************************************************************
  // every cell starts erased, all ones
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = cml_pkg::BLANK_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

//--- hdl/cml_pkg.sv
// shared constants, types and helpers for the code memory lock block
package cml_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int CODE_BYTES = 8192;
  localparam int ENC_BYTES = 64;
  localparam int SIG_BYTES = 4;
  localparam int CODE_AW = 13;
  localparam int ENC_AW = 6;
  localparam int SIG_AW = 2;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;

  // ************************************************************
  // apb register map (byte addresses)
  // ************************************************************
  localparam int APB_AW = 12;
  localparam logic [11:0] OFF_ADDR = 12'h000;
  localparam logic [11:0] OFF_WDATA = 12'h004;
  localparam logic [11:0] OFF_CMD = 12'h008;
  localparam logic [11:0] OFF_RDATA = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;

  // status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int STAT_EA_BIT = 2;
  localparam int STAT_EXEC_BIT = 3;
  localparam int STAT_LEVEL_LSB = 4;
  localparam int STAT_LOCK_LSB = 8;

  // reset values
  localparam logic [12:0] ADDR_RST = 13'h0000;
  localparam logic [7:0] WDATA_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [31:0] APB_RDATA_RST = 32'h0000_0000;

  // ************************************************************
  // security levels and commands
  // ************************************************************
  localparam logic [2:0] LEVEL_1 = 3'h1;
  localparam logic [2:0] LEVEL_2 = 3'h2;
  localparam logic [2:0] LEVEL_3 = 3'h3;
  localparam logic [2:0] LEVEL_4 = 3'h4;

  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_PROG_CODE,
    CMD_PROG_ENC,
    CMD_PROG_LOCK1,
    CMD_PROG_LOCK2,
    CMD_PROG_LOCK3,
    CMD_VERIFY,
    CMD_READ_SIG
  } cml_cmd_t;

  // factory signature, values arbitrary
  localparam logic [3:0][7:0] SIG_VALUES = {8'h3C, 8'hC3, 8'hA5, 8'h5A};

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic three;
    logic two;
    logic one;
  } cml_lock_t;

  typedef struct packed {
    logic req;
    logic ext;
    logic [12:0] addr;
  } cml_core_req_t;

  typedef struct packed {
    logic valid;
    logic blocked;
    logic [7:0] data;
  } cml_core_rsp_t;

  // highest level named by any programmed lock bit wins
  function automatic logic [2:0] sec_level(input cml_lock_t lk);
    if (lk.three) begin
      return LEVEL_4;
    end else if (lk.two) begin
      return LEVEL_3;
    end else if (lk.one) begin
      return LEVEL_2;
    end
    return LEVEL_1;
  endfunction

endpackage

//--- hdl/cml_top.sv
// code memory lock, encryption and signature logic with apb access
// Notes on behaviour
// - store holds 8 KB code, 64 B encryption and 4 B signature arrays
// - encryption bytes read as all ones until programmed
// - six low address lines pick the encryption byte on verify
// - verify returns code byte xnor encryption byte
// - blank encryption array leaves verify equal to stored code
// - verifying an all ones code byte returns the encryption byte
// - no lock bits means level 1, verify still encrypted
// - level 1 external code-table reads get plain internal bytes
// - lock bit one gives level 2, external code-table reads blocked
// - level 2 and up uses external access pin caught at reset
// - erasable part refuses code and encryption programming at level 2 and up, lock bits stay programmable
// - lock bit two gives level 3, verify also refused
// - lock bit three gives level 4, external execution disabled
// - signature is fixed, no path can alter it
// - encryption array has no direct read path
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cml_top #(
  parameter bit ERASABLE = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core code-table read port
  input wire cml_pkg::cml_core_req_t core_req,
  output cml_pkg::cml_core_rsp_t core_rsp,
  // external access select
  input wire logic external_access_select,
  output logic ext_access_eff,
  output logic ext_exec_allow
);

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_READ} cml_state_t;

  cml_state_t state;
  cml_pkg::cml_cmd_t op;
  cml_pkg::cml_lock_t lock;
  logic [12:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic refused;
  logic ea_latched;
  logic rst_seen;
  logic core_pend;
  logic core_ext_q;
  logic [7:0] code_rd;
  logic [7:0] enc_rd;
  logic [2:0] level;
  logic prog_lock;
  logic go;
  logic code_we;
  logic enc_we;
  logic apb_wr;
  logic cmd_wr;
  logic refuse_now;
  logic clr_refused;
  logic [12:0] code_raddr;

  // ************************************************************
  // level decode
  // ************************************************************
  assign level = cml_pkg::sec_level(lock);
  assign prog_lock = ERASABLE && (level >= cml_pkg::LEVEL_2);
  assign go = (state == S_WAIT) && !core_req.req;
  assign apb_wr = psel && penable && pready && pwrite;
  assign cmd_wr = apb_wr && (paddr == cml_pkg::OFF_CMD);
  assign clr_refused = apb_wr && (paddr == cml_pkg::OFF_STATUS)
                       && pwdata[cml_pkg::STAT_REFUSED_BIT];

  // signature has no write enable at all
  assign code_we = go && (op == cml_pkg::CMD_PROG_CODE) && !prog_lock;
  assign enc_we = go && (op == cml_pkg::CMD_PROG_ENC) && !prog_lock;
  assign code_raddr = core_req.req ? core_req.addr : addr;

  // refusals: busy on command write, locked programming, locked verify
  always_comb begin
    refuse_now = cmd_wr && (state != S_IDLE);
    if (go) begin
      case (op)
        cml_pkg::CMD_PROG_CODE,
        cml_pkg::CMD_PROG_ENC: refuse_now = refuse_now || prog_lock;
        cml_pkg::CMD_VERIFY: refuse_now = refuse_now || (level >= cml_pkg::LEVEL_3);
        default: refuse_now = refuse_now;
      endcase
    end
  end

  // ************************************************************
  // arrays
  // ************************************************************
  cml_mem #(.AW(cml_pkg::CODE_AW), .DEPTH(cml_pkg::CODE_BYTES)) u_code (
    .clk(pclk),
    .we(code_we),
    .waddr(addr),
    .wdata(wdata),
    .raddr(code_raddr),
    .rdata(code_rd)
  );

  // blank-filled, so unprogrammed bytes act as ones
  cml_mem #(.AW(cml_pkg::ENC_AW), .DEPTH(cml_pkg::ENC_BYTES)) u_enc (
    .clk(pclk),
    .we(enc_we),
    .waddr(addr[5:0]),
    .wdata(wdata),
    .raddr(addr[5:0]),
    .rdata(enc_rd)
  );

  // ************************************************************
  // apb slave
  // ************************************************************
  // one wait-free access: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= cml_pkg::APB_RDATA_RST;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= cml_pkg::APB_RDATA_RST;
      if (psel && !penable) begin
        case (paddr)
          cml_pkg::OFF_ADDR: prdata <= {19'h00000, addr};
          cml_pkg::OFF_WDATA: prdata <= {24'h000000, wdata};
          cml_pkg::OFF_CMD: prdata <= {28'h0000000, op};
          // no offset returns the encryption array itself
          cml_pkg::OFF_RDATA: prdata <= {24'h000000, rdata};
          cml_pkg::OFF_STATUS: begin
            prdata[cml_pkg::STAT_BUSY_BIT] <= state != S_IDLE;
            prdata[cml_pkg::STAT_REFUSED_BIT] <= refused;
            prdata[cml_pkg::STAT_EA_BIT] <= ext_access_eff;
            prdata[cml_pkg::STAT_EXEC_BIT] <= ext_exec_allow;
            prdata[cml_pkg::STAT_LEVEL_LSB +: 3] <= level;
            prdata[cml_pkg::STAT_LOCK_LSB +: 3] <= lock;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= cml_pkg::ADDR_RST;
      wdata <= cml_pkg::WDATA_RST;
    end else if (apb_wr && (state == S_IDLE)) begin
      if (paddr == cml_pkg::OFF_ADDR) begin
        addr <= pwdata[12:0];
      end
      if (paddr == cml_pkg::OFF_WDATA) begin
        wdata <= pwdata[7:0];
      end
    end
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused <= 1'b0;
    end else if (refuse_now) begin
      refused <= 1'b1;
    end else if (clr_refused) begin
      refused <= 1'b0;
    end
  end

  // ************************************************************
  // command sequencer
  // ************************************************************
  // core fetches take the code port first; commands wait in S_WAIT
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      op <= cml_pkg::CMD_NONE;
    end else begin
      case (state)
        S_IDLE: begin
          if (cmd_wr && (pwdata[3:0] <= 4'(cml_pkg::CMD_READ_SIG))
              && (pwdata[3:0] != 4'(cml_pkg::CMD_NONE))) begin
            op <= cml_pkg::cml_cmd_t'(pwdata[3:0]);
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (go) begin
            state <= (op == cml_pkg::CMD_VERIFY && level < cml_pkg::LEVEL_3) ? S_READ : S_IDLE;
          end
        end
        S_READ: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // lock bits only go from unprogrammed to programmed; reset clears all three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= '0;
    end else if (go) begin
      lock.one <= lock.one || (op == cml_pkg::CMD_PROG_LOCK1);
      lock.two <= lock.two || (op == cml_pkg::CMD_PROG_LOCK2);
      lock.three <= lock.three || (op == cml_pkg::CMD_PROG_LOCK3);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= cml_pkg::RDATA_RST;
    end else if (state == S_READ) begin
      rdata <= ~(code_rd ^ enc_rd);
    end else if (go && op == cml_pkg::CMD_READ_SIG) begin
      rdata <= cml_pkg::SIG_VALUES[addr[1:0]];
    end
  end

  // ************************************************************
  // core code-table reads and external access
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_pend <= 1'b0;
      core_ext_q <= 1'b0;
      core_rsp <= '0;
    end else begin
      core_pend <= core_req.req;
      core_ext_q <= core_req.ext;
      core_rsp.valid <= core_pend;
      core_rsp.blocked <= 1'b0;
      if (core_pend) begin
        if (core_ext_q && level >= cml_pkg::LEVEL_2) begin
          core_rsp.blocked <= 1'b1;
          core_rsp.data <= 8'h00;
        end else begin
          core_rsp.data <= code_rd;
        end
      end
    end
  end

  // pin caught once at the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_seen <= 1'b0;
      ea_latched <= 1'b0;
    end else if (!rst_seen) begin
      rst_seen <= 1'b1;
      ea_latched <= external_access_select;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_access_eff <= 1'b0;
      ext_exec_allow <= 1'b0;
    end else begin
      ext_access_eff <= (level >= cml_pkg::LEVEL_2) ? ea_latched
                                                    : external_access_select;
      ext_exec_allow <= level < cml_pkg::LEVEL_4;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_level_map;
    @(posedge pclk) disable iff (!presetn)
      lock.one && !lock.two && !lock.three |-> level == 3'h2;
  endproperty
  a_level_map: assert property (p_level_map) else $error("lock one not level 2");
  property p_level_max;
    @(posedge pclk) disable iff (!presetn)
      lock.three |-> level == 3'h4 ##1 !ext_exec_allow;
  endproperty
  a_level_max: assert property (p_level_max) else $error("lock three not highest");
  property p_verify_xnor;
    @(posedge pclk) disable iff (!presetn)
      state == S_READ |=> rdata == ~($past(code_rd) ^ $past(enc_rd));
  endproperty
  a_verify_xnor: assert property (p_verify_xnor) else $error("verify not xnor");
  property p_blank_enc;
    @(posedge pclk) disable iff (!presetn)
      state == S_READ && enc_rd == 8'hFF |=> rdata == $past(code_rd);
  endproperty
  a_blank_enc: assert property (p_blank_enc) else $error("blank key altered code");
  property p_blank_code;
    @(posedge pclk) disable iff (!presetn)
      state == S_READ && code_rd == 8'hFF |=> rdata == $past(enc_rd);
  endproperty
  a_blank_code: assert property (p_blank_code) else $error("blank code not key");
  property p_core_block;
    @(posedge pclk) disable iff (!presetn)
      core_req.req && core_req.ext && level >= 3'h2 && $stable(lock)
      |-> ##2 core_rsp.valid && core_rsp.blocked;
  endproperty
  a_core_block: assert property (p_core_block) else $error("external read not blocked");
  property p_core_plain;
    @(posedge pclk) disable iff (!presetn)
      core_req.req && level == 3'h1 ##1 level == 3'h1
      |-> ##1 core_rsp.valid && !core_rsp.blocked && core_rsp.data == $past(code_rd);
  endproperty
  a_core_plain: assert property (p_core_plain) else $error("level 1 read wrong");
  property p_ea_hold;
    @(posedge pclk) disable iff (!presetn)
      rst_seen && level >= 3'h2 |=> ext_access_eff == ea_latched;
  endproperty
  a_ea_hold: assert property (p_ea_hold) else $error("pin not held");
  property p_no_prog;
    @(posedge pclk) disable iff (!presetn)
      level >= 3'h2 && ERASABLE |-> !code_we && !enc_we;
  endproperty
  a_no_prog: assert property (p_no_prog) else $error("locked array written");
  property p_no_verify;
    @(posedge pclk) disable iff (!presetn)
      go && op == cml_pkg::CMD_VERIFY && level >= 3'h3
      |=> state == S_IDLE && refused && $stable(rdata);
  endproperty
  a_no_verify: assert property (p_no_verify) else $error("locked verify ran");

endmodule
`default_nettype wire
